// ### dds_regs.svh
// Purpose: constants shared by both ends of the waveform core link
// Assumes: 100 MHz clk_sys on both ends
// Notes:   field positions refer to the 16-bit serial word
`ifndef DDS_REGS_SVH
`define DDS_REGS_SVH

`define DDS_WORD_BITS       16
`define DDS_ACC_BITS        28
`define DDS_PHASE_BITS      12
`define DDS_DAC_BITS        10
`define DDS_MIDSCALE        10'h200
`define DDS_CLK_MHZ         100
`define DDS_LATENCY_CYCLES  7
`define DDS_FIXED_STAGES    4
`define DDS_DELAY_STAGES    (`DDS_LATENCY_CYCLES - `DDS_FIXED_STAGES)

// word kind in bits 15:14
`define DDS_KIND_CTRL       2'h0
`define DDS_KIND_FREQ_A     2'h1
`define DDS_KIND_FREQ_B     2'h2
`define DDS_KIND_PHASE      2'h3
`define DDS_PHASE_SEL_BIT   13

// control word bits
`define DDS_CTL_PAIR        13
`define DDS_CTL_HIGH_HALF   12
`define DDS_CTL_FREQ_SEL    11
`define DDS_CTL_PHASE_SEL   10
`define DDS_CTL_RESET       8
`define DDS_CTL_MODE        1
`define DDS_CTL_RESET_VAL   14'h0000

// host apb map
`define DDS_APB_DATA        12'h000
`define DDS_APB_STATUS      12'h004
`define DDS_APB_DIV         12'h008
`define DDS_DIV_RESET       16'h0004
`define DDS_DIV_MIN         16'h0002

`endif

// ### dds_pkg.sv
// Purpose: types shared by both ends of the waveform core link
// Assumes: nothing
// Notes:   constants live in dds_regs.svh
`default_nettype none
package dds_pkg;
   typedef logic [15:0] dds_word_t;
   typedef enum {HOST_IDLE, HOST_SETUP, HOST_SHIFT, HOST_END} dds_host_state_t;
endpackage : dds_pkg
`default_nettype wire

// ### dds_link_if.sv
// Purpose: three-wire serial link between host and waveform core
// Assumes: host drives all three wires
// Notes:   serial clock is a plain signal here, not a clock domain
`timescale 1ns/10ps
`default_nettype none
interface dds_link_if;
   logic serialClk;
   logic frameSyncN;
   logic serialDataIn;
   modport host   (output serialClk, output frameSyncN, output serialDataIn);
   modport device (input serialClk, input frameSyncN, input serialDataIn);
endinterface : dds_link_if
`default_nettype wire

// ### dds_device_end.sv
// Purpose: waveform core: serial word intake, phase oscillator, sine stage
// Assumes: link pins are asynchronous to clk_sys and slow against it
// Notes:   sine stage is a parabolic approximation, no stored table
//
// Behaviour
// - 28-bit accumulator adds selected word, wraps
// - output frequency is word times clock over 2^28
// - frequency select bit picks word a or b
// - switching word never touches accumulator
// - add selected 12-bit offset to top bits
// - two offset registers, step is 1/4096 cycle
// - truncate phase sum to upper 12 bits
// - sine stage maps 12-bit address to 10-bit code
// - mode bit D1 enables or bypasses sine
// - 16 bits per word on serial clock falls
// - accept data only while frame sync low
// - host raises frame sync only after 16th fall
// - serial clock high when frame sync falls
// - reset bit clears datapath, output at midscale
// - reset bit leaves word and control registers
// - host resets core after power-up
// - host holds reset bit while loading registers
// - output follows reset release in 7-8 cycles
// - output follows register load in 7-8 cycles
// - top bits 00 means control word write
// - control bits except mode take effect later
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "dds_regs.svh"

module dds_device_end #(
   parameter int ACC_BITS   = `DDS_ACC_BITS,
   parameter int DELAY_STGS = `DDS_DELAY_STAGES
) (
   // system
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   // serial link
   dds_link_if.device                    link,
   // converter side
   output logic [`DDS_DAC_BITS-1:0]      dacCode,
   output logic                          wordStrobe
);

   localparam int SCK = 0;
   localparam int FS  = 1;
   localparam int SD  = 2;

   logic [2:0]                   pinSync1_reg;
   logic [2:0]                   pinSync2_reg;
   logic                         sclkLast_reg;
   logic                         sclkFall;
   logic [3:0]                   bitCount_reg;
   dds_pkg::dds_word_t           shift_reg;
   dds_pkg::dds_word_t           word_reg;
   logic                         wordValid_reg;
   logic [13:0]                  ctrlStage_reg;
   logic                         ctrlLoad_reg;
   logic                         ctrlPair_reg;
   logic                         ctrlHighHalf_reg;
   logic                         freqWordSelect_reg;
   logic                         phaseWordSelect_reg;
   logic                         ctrlReset_reg;
   logic                         modeBypass_reg;
   logic [ACC_BITS-1:0]          freqWord_reg [2];
   logic [13:0]                  lowHold_reg;
   logic                         lowHeld_reg;
   logic [`DDS_PHASE_BITS-1:0]   phaseOffset_reg [2];
   logic [ACC_BITS-1:0]          phaseAcc_reg;
   logic [`DDS_PHASE_BITS-1:0]   phaseSum_reg;
   logic [`DDS_PHASE_BITS-1:0]   phaseOffSel_reg;
   logic                         romHold_reg;
   logic [`DDS_DAC_BITS-1:0]     romCode_reg;
   logic [`DDS_DAC_BITS-1:0]     delay_reg [DELAY_STGS+1];
   logic                         freqIdx;

   // parabolic half-wave approximation of sine, offset binary
   function automatic logic [`DDS_DAC_BITS-1:0] sineCode(input logic [11:0] addr);
      logic [10:0] x;
      logic [11:0] rest;
      logic [22:0] prod;
      logic [9:0]  amp;
      logic [9:0]  ampPos;
      x      = addr[10:0];
      rest   = 12'h800 - {1'b0, x};
      prod   = 23'(x) * 23'(rest);
      amp    = prod[20:11];
      ampPos = (amp > 10'h1ff) ? 10'h1ff : amp;
      sineCode = addr[11] ? (`DDS_MIDSCALE - amp) : (`DDS_MIDSCALE + ampPos);
   endfunction : sineCode

   // pin synchronisers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pinSync1_reg <= 3'h3;
         pinSync2_reg <= 3'h3;
         sclkLast_reg <= 1'b1;
      end else begin
         pinSync1_reg <= {link.serialDataIn, link.frameSyncN, link.serialClk};
         pinSync2_reg <= pinSync1_reg;
         sclkLast_reg <= pinSync2_reg[SCK];
      end
   end

   assign sclkFall = sclkLast_reg & ~pinSync2_reg[SCK];

   // word assembly on serial clock falls
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bitCount_reg  <= 4'h0;
         shift_reg     <= 16'h0000;
         word_reg      <= 16'h0000;
         wordValid_reg <= 1'b0;
      end else begin
         wordValid_reg <= 1'b0;
         if (pinSync2_reg[FS]) begin
            bitCount_reg <= 4'h0;
         end else if (sclkFall) begin
            shift_reg    <= {shift_reg[14:0], pinSync2_reg[SD]};
            bitCount_reg <= bitCount_reg + 4'h1;
            if (bitCount_reg == 4'hf) begin
               word_reg      <= {shift_reg[14:0], pinSync2_reg[SD]};
               wordValid_reg <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wordStrobe <= 1'b0;
      end else begin
         wordStrobe <= wordValid_reg;
      end
   end

   // control word: mode at once, the rest one cycle later
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrlStage_reg  <= `DDS_CTL_RESET_VAL;
         ctrlLoad_reg   <= 1'b0;
         modeBypass_reg <= 1'b0;
      end else begin
         ctrlLoad_reg <= 1'b0;
         if (wordValid_reg && word_reg[15:14] == `DDS_KIND_CTRL) begin
            ctrlStage_reg  <= word_reg[13:0];
            ctrlLoad_reg   <= 1'b1;
            modeBypass_reg <= word_reg[`DDS_CTL_MODE];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrlPair_reg        <= 1'b0;
         ctrlHighHalf_reg    <= 1'b0;
         freqWordSelect_reg  <= 1'b0;
         phaseWordSelect_reg <= 1'b0;
         ctrlReset_reg       <= 1'b0;
      end else if (ctrlLoad_reg) begin
         ctrlPair_reg        <= ctrlStage_reg[`DDS_CTL_PAIR];
         ctrlHighHalf_reg    <= ctrlStage_reg[`DDS_CTL_HIGH_HALF];
         freqWordSelect_reg  <= ctrlStage_reg[`DDS_CTL_FREQ_SEL];
         phaseWordSelect_reg <= ctrlStage_reg[`DDS_CTL_PHASE_SEL];
         ctrlReset_reg       <= ctrlStage_reg[`DDS_CTL_RESET];
      end
   end

   assign freqIdx = (word_reg[15:14] == `DDS_KIND_FREQ_B);

   // frequency words, paired or by half
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         freqWord_reg[0] <= '0;
         freqWord_reg[1] <= '0;
         lowHold_reg     <= 14'h0000;
         lowHeld_reg     <= 1'b0;
      end else if (wordValid_reg && (word_reg[15:14] == `DDS_KIND_FREQ_A ||
                                     word_reg[15:14] == `DDS_KIND_FREQ_B)) begin
         if (ctrlPair_reg) begin
            if (!lowHeld_reg) begin
               lowHold_reg <= word_reg[13:0];
               lowHeld_reg <= 1'b1;
            end else begin
               freqWord_reg[freqIdx] <= {word_reg[13:0], lowHold_reg};
               lowHeld_reg           <= 1'b0;
            end
         end else if (ctrlHighHalf_reg) begin
            freqWord_reg[freqIdx][27:14] <= word_reg[13:0];
         end else begin
            freqWord_reg[freqIdx][13:0] <= word_reg[13:0];
         end
      end
   end

   // phase offsets, one step is 1/4096 of a period
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phaseOffset_reg[0] <= '0;
         phaseOffset_reg[1] <= '0;
      end else if (wordValid_reg && word_reg[15:14] == `DDS_KIND_PHASE) begin
         phaseOffset_reg[word_reg[`DDS_PHASE_SEL_BIT]] <= word_reg[11:0];
      end
   end

   // phase oscillator; fout = word * fclk / 2^28
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phaseAcc_reg <= '0;
      end else if (ctrlReset_reg) begin
         phaseAcc_reg <= '0;
      end else begin
         phaseAcc_reg <= phaseAcc_reg + freqWord_reg[freqWordSelect_reg];
      end
   end

   // offset staged once so phase loads see the same latency as frequency loads
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phaseOffSel_reg <= '0;
         phaseSum_reg    <= '0;
      end else begin
         phaseOffSel_reg <= phaseOffset_reg[phaseWordSelect_reg];
         if (ctrlReset_reg) begin
            phaseSum_reg <= '0;
         end else begin
            phaseSum_reg <= phaseAcc_reg[ACC_BITS-1 -: `DDS_PHASE_BITS]
                            + phaseOffSel_reg;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         romHold_reg <= 1'b0;
         romCode_reg <= `DDS_MIDSCALE;
      end else begin
         romHold_reg <= ctrlReset_reg;
         if (ctrlReset_reg || romHold_reg) begin
            romCode_reg <= `DDS_MIDSCALE;
         end else if (modeBypass_reg) begin
            romCode_reg <= phaseSum_reg[11:2];
         end else begin
            romCode_reg <= sineCode(phaseSum_reg);
         end
      end
   end

   // output delay line sets the 7-cycle load-to-output latency
   assign delay_reg[0] = romCode_reg;
   for (genvar i = 1; i <= DELAY_STGS; i++) begin : g_delay
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            delay_reg[i] <= `DDS_MIDSCALE;
         end else begin
            delay_reg[i] <= delay_reg[i-1];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dacCode <= `DDS_MIDSCALE;
      end else begin
         dacCode <= delay_reg[DELAY_STGS];
      end
   end

endmodule : dds_device_end
`default_nettype wire

// ### dds_host_end.sv
// Purpose: host serial port controller for the waveform core, apb slave
// Assumes: zero-wait apb master on clk_sys
// Notes:   one word in flight; data writes while busy get pslverr
`timescale 1ns/10ps
`default_nettype none
`include "dds_regs.svh"

module dds_host_end (
   // system
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // apb
   input  wire logic [11:0]  paddr,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   // serial link
   dds_link_if.host          link
);

   dds_pkg::dds_host_state_t state_reg;
   dds_pkg::dds_word_t       txShift_reg;
   dds_pkg::dds_word_t       lastWord_reg;
   logic [15:0]              div_reg;
   logic [15:0]              divCount_reg;
   logic [4:0]               fallCount_reg;
   logic                     tick;
   logic                     busy;
   logic                     setupPhase;
   logic                     doWrite;
   logic                     mapped;

   assign setupPhase = psel & ~penable;
   assign doWrite    = psel & penable & pready & pwrite & ~pslverr;
   assign busy       = (state_reg != dds_pkg::HOST_IDLE);
   assign mapped     = (paddr == `DDS_APB_DATA) || (paddr == `DDS_APB_STATUS) ||
                       (paddr == `DDS_APB_DIV);
   assign tick       = (divCount_reg >= div_reg - 16'h1);

   // apb answer prepared in setup, given in first access cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= setupPhase;
         pslverr <= setupPhase & (~mapped | (pwrite & busy & paddr == `DDS_APB_DATA));
         prdata  <= 32'h0;
         if (setupPhase && !pwrite) begin
            unique case (paddr)
               `DDS_APB_DATA:   prdata <= {16'h0, lastWord_reg};
               `DDS_APB_STATUS: prdata <= {31'h0, busy};
               `DDS_APB_DIV:    prdata <= {16'h0, div_reg};
               default:         prdata <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div_reg <= `DDS_DIV_RESET;
      end else if (doWrite && paddr == `DDS_APB_DIV) begin
         div_reg <= (pwdata[15:0] < `DDS_DIV_MIN) ? `DDS_DIV_MIN : pwdata[15:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         divCount_reg <= 16'h0;
      end else if (!busy || tick) begin
         divCount_reg <= 16'h0;
      end else begin
         divCount_reg <= divCount_reg + 16'h1;
      end
   end

   // frame sequencer: data changes on rising, device samples on falling
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg         <= dds_pkg::HOST_IDLE;
         txShift_reg       <= 16'h0;
         lastWord_reg      <= 16'h0;
         fallCount_reg     <= 5'h0;
         link.serialClk    <= 1'b1;
         link.frameSyncN   <= 1'b1;
         link.serialDataIn <= 1'b0;
      end else begin
         unique case (state_reg)
            dds_pkg::HOST_IDLE: begin
               if (doWrite && paddr == `DDS_APB_DATA) begin
                  txShift_reg       <= pwdata[15:0];
                  lastWord_reg      <= pwdata[15:0];
                  link.serialDataIn <= pwdata[15];
                  link.frameSyncN   <= 1'b0;
                  fallCount_reg     <= 5'h0;
                  state_reg         <= dds_pkg::HOST_SETUP;
               end
            end
            dds_pkg::HOST_SETUP: begin
               if (tick) begin
                  state_reg <= dds_pkg::HOST_SHIFT;
               end
            end
            dds_pkg::HOST_SHIFT: begin
               if (tick && link.serialClk) begin
                  link.serialClk <= 1'b0;
                  fallCount_reg  <= fallCount_reg + 5'h1;
               end else if (tick) begin
                  link.serialClk <= 1'b1;
                  if (fallCount_reg == 5'd16) begin
                     state_reg <= dds_pkg::HOST_END;
                  end else begin
                     txShift_reg       <= {txShift_reg[14:0], 1'b0};
                     link.serialDataIn <= txShift_reg[14];
                  end
               end
            end
            dds_pkg::HOST_END: begin
               if (tick) begin
                  link.frameSyncN <= 1'b1;
                  state_reg       <= dds_pkg::HOST_IDLE;
               end
            end
         endcase
      end
   end

endmodule : dds_host_end
`default_nettype wire

// ### dds_link_sva.sv
// Purpose: link and converter checks for the waveform core pair
// Assumes: host idles serial clock high, half period >= 2 clk
// Notes:   fallCount_reg counts serial clock falls within one frame
`timescale 1ns/10ps
`default_nettype none
module dds_link_sva (
   // system
   input wire logic       clk_sys,
   input wire logic       rst,
   // serial link
   input wire logic       serialClk,
   input wire logic       frameSyncN,
   input wire logic       serialDataIn,
   // converter side
   input wire logic [9:0] dacCode,
   input wire logic       wordStrobe
);
   logic [4:0] fallCount_reg;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) fallCount_reg <= 5'h00;
      else if (frameSyncN) fallCount_reg <= 5'h00;
      else if ($fell(serialClk)) fallCount_reg <= fallCount_reg + 5'h01;
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_start_high; $fell(frameSyncN) |-> serialClk; endproperty
   property p_idle_high; frameSyncN |-> serialClk; endproperty
   property p_sixteen; $rose(frameSyncN) |-> fallCount_reg == 5'h10; endproperty
   property p_stable_fall; $fell(serialClk) |-> $stable(serialDataIn); endproperty
   property p_data_on_rise;
      !frameSyncN && $changed(serialDataIn) |-> $rose(serialClk) || $fell(frameSyncN);
   endproperty
   property p_half_period; $changed(serialClk) |=> $stable(serialClk); endproperty
   property p_strobe;
      $fell(serialClk) && !frameSyncN && fallCount_reg == 5'h0f |-> ##[2:5] wordStrobe;
   endproperty
   property p_pulse; wordStrobe |=> !wordStrobe; endproperty
   property p_mid; $fell(rst) |-> dacCode == 10'h200; endproperty

   a_start_high: assert property (p_start_high) else $error("clock low at frame start");
   a_idle_high: assert property (p_idle_high) else $error("clock moves outside frame");
   a_sixteen: assert property (p_sixteen) else $error("frame not 16 falls");
   a_stable_fall: assert property (p_stable_fall) else $error("data moves at fall");
   a_data_on_rise: assert property (p_data_on_rise) else $error("data moves off rise");
   a_half_period: assert property (p_half_period) else $error("serial clock too fast");
   a_strobe: assert property (p_strobe) else $error("no word strobe");
   a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
   a_mid: assert property (p_mid) else $error("output not midscale after reset");

   c_frame: cover property ($rose(frameSyncN));
   c_strobe: cover property (wordStrobe);
   c_output: cover property ($changed(dacCode) && dacCode != 10'h200);
endmodule : dds_link_sva
`default_nettype wire

// ### dds_waveform_core_tb_top.sv
// Purpose: host and core joined over the link, driven over apb
// Assumes: output change 7 or 8 clk after the word strobe
// Notes:   bypass mode with rate k<<18 steps the code by k each clk
`timescale 1ns/10ps
`default_nettype none
`include "dds_regs.svh"
module dds_waveform_core_tb_top;
   logic        clk_sys;
   logic        rst;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [9:0]  dacCode;
   logic        wordStrobe;
   logic [31:0] rd;
   logic        er;
   logic [9:0]  k;
   logic [9:0]  k2;
   logic [9:0]  m;
   logic [9:0]  m2;
   logic [11:0] ph;
   int          errCount = 0;
   int          checks = 0;
   int          cycles = 0;
   int          seed;

   dds_link_if linkIf ();
   dds_host_end dds_host_end_inst (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .link(linkIf));
   dds_device_end dds_device_end_inst (.clk_sys, .rst, .link(linkIf), .dacCode, .wordStrobe);
   dds_link_sva dds_link_sva_inst (.clk_sys, .rst, .serialClk(linkIf.serialClk),
      .frameSyncN(linkIf.frameSyncN), .serialDataIn(linkIf.serialDataIn), .dacCode,
      .wordStrobe);

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic end_of_test();
      $display("checks=%0d errors=%0d", checks, errCount);
      if (errCount == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   always @(posedge clk_sys) begin
      cycles = cycles + 1;
      if (cycles >= 30000) begin
         errCount++;
         end_of_test();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errCount++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // waits for idle, sends one word, returns at the edge that sees the strobe
   task automatic send(input logic [15:0] w);
      logic [31:0] r;
      logic        e;
      do apb(1'b0, `DDS_APB_STATUS, 32'h0, r, e); while (r[0] !== 1'b0);
      apb(1'b1, `DDS_APB_DATA, {16'h0000, w}, r, e);
      check(32'(e), 32'h0);
      do @(posedge clk_sys); while (wordStrobe !== 1'b1);
   endtask : send

   function automatic logic [9:0] exp_diff(input int i, input int at, input logic [9:0] k1,
                                           input logic [9:0] kn, input logic [9:0] j);
      if (i < at) return k1;
      if (i == at) return kn + j;
      return kn;
   endfunction : exp_diff

   function automatic logic [9:0] sine_of(input logic [11:0] p);
      int x;
      int mg;
      x  = int'(p[10:0]);
      mg = x * (2048 - x) / 2048;
      if (p[11]) return 10'(512 - mg);
      return 10'(512 + ((mg > 511) ? 511 : mg));
   endfunction : sine_of

   // per-cycle code steps k1, then kn plus jump j at step 7 or 8
   task automatic watch(input logic [9:0] k1, input logic [9:0] kn, input logic [9:0] j);
      logic [9:0] prv;
      logic [9:0] di;
      logic       ok7;
      logic       ok8;
      prv = dacCode;
      ok7 = 1'b1;
      ok8 = 1'b1;
      for (int i = 1; i <= 14; i++) begin
         @(posedge clk_sys);
         di  = dacCode - prv;
         prv = dacCode;
         ok7 &= (di === exp_diff(i, 7, k1, kn, j));
         ok8 &= (di === exp_diff(i, 8, k1, kn, j));
      end
      check({31'h0, ok7 | ok8}, 32'h1);
   endtask : watch

   initial begin
      seed    = 32'h56db;
      rst     = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      check(32'(dacCode), 32'(`DDS_MIDSCALE));
      apb(1'b0, `DDS_APB_DIV, 32'h0, rd, er);
      check(rd, {16'h0000, `DDS_DIV_RESET});
      apb(1'b0, 12'h00c, 32'h0, rd, er);
      check(32'(er), 32'h1);
      apb(1'b1, `DDS_APB_DIV, {16'h0000, `DDS_DIV_MIN}, rd, er);
      send(16'h0000);
      for (int i = 0; i < 6; i++) begin
         ph = (i == 0) ? 12'h400 : (i == 1) ? 12'hc00 : 12'($random(seed));
         send({4'hc, ph});
         repeat (14) @(posedge clk_sys);
         check(32'(dacCode), 32'(sine_of(ph)));
      end
      k  = 10'(($random(seed) & 15) | 1);
      k2 = k + 10'(1 + ($random(seed) & 7));
      m  = 10'($random(seed));
      m2 = 10'($random(seed));
      send(16'h2102);
      send({2'h1, 14'h0000});
      send({2'h1, k, 4'h0});
      send(16'hc000);
      send(16'h2002);
      repeat (6) @(posedge clk_sys);
      check(32'(dacCode), 32'(`DDS_MIDSCALE));
      repeat (3) @(posedge clk_sys);
      check(32'(dacCode == 10'h200), 32'h0);
      send({4'hc, m, 2'h0});
      watch(k, k, m);
      send(16'h1002);
      send({2'h2, k2, 4'h0});
      send(16'h1802);
      watch(k, k2, 10'h000);
      send({4'he, m2, 2'h0});
      send(16'h1c02);
      watch(k2, k2, m2 - m);
      send(16'h1d02);
      repeat (10) @(posedge clk_sys);
      check(32'(dacCode), 32'(`DDS_MIDSCALE));
      send(16'h1c02);
      repeat (14) @(posedge clk_sys);
      watch(k2, k2, 10'h000);
      apb(1'b1, `DDS_APB_DATA, 32'h0000_1c02, rd, er);
      apb(1'b1, `DDS_APB_DATA, 32'h0000_0102, rd, er);
      check(32'(er), 32'h1);
      apb(1'b0, `DDS_APB_STATUS, 32'h0, rd, er);
      check(32'(rd[0]), 32'h1);
      apb(1'b0, `DDS_APB_DATA, 32'h0, rd, er);
      check({16'h0000, rd[15:0]}, 32'h0000_1c02);
      end_of_test();
   end
endmodule : dds_waveform_core_tb_top
`default_nettype wire
